// >>> src/spi_port_ctrl.sv
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module spi_port_ctrl (
  input  wire logic                   CLK_IN,
  input  wire logic                   RST_N_IN,
  input  wire logic                   IDLE_MODE_IN,
  input  wire spi_port_pkg::axi_req_t AXI_REQ_IN,
  output spi_port_pkg::axi_rsp_t      AXI_RSP_OUT,
  input  wire logic                   SCK_IN,
  output logic                        SCK_OUT,
  output logic                        SCK_OE_OUT,
  output logic                        SDO_OUT,
  output logic                        SDO_OE_OUT,
  input  wire logic                   SDI_IN,
  input  wire logic                   SS_IN,
  output logic                        SS_OUT,
  output logic                        SS_OE_OUT,
  output logic                        BUFFER_EVENT_OUT
);
  import spi_port_pkg::*;

  typedef enum logic [1:0] {ENG_IDLE, ENG_PRE, ENG_SHIFT} eng_t;

  // Whole state of the port
  typedef struct packed {
    axi_rsp_t          rsp;      // Bus answer flops
    logic              aw_held;  // Write address captured
    logic [ADDR_W-1:0] awaddr;
    logic              w_held;   // Write data captured
    logic [15:0]       wdata;
    logic [1:0]        wstrb;
    logic              en;       // Port enable
    logic              sidl;     // Stop in idle
    logic [2:0]        buffer_irq_select;    // Buffer event select
    logic              rov;      // Receive overflow
    logic              master;   // Master mode
    logic              cke;      // Clock edge select
    logic [1:0]        primary_prescale;     // Primary prescale
    logic              framed_enable;    // Framed enable
    logic              fsd;      // Frame sync direction
    logic              fpol;     // Frame sync polarity
    logic              fe;       // Frame sync edge
    logic              ben;      // Enhanced buffer
    logic [2:0]        sck_sy;   // Clock pin synchroniser and history
    logic [1:0]        sdi_sy;   // Data pin synchroniser
    logic [1:0]        ss_sy;    // Select pin synchroniser
    eng_t              st;       // Engine state
    logic [3:0]        hb;       // Half bit or sample count
    logic [7:0]        sr;       // Shift register
    logic              fs_act;   // Frame pulse active
    logic              sck_o;
    logic              sdo_o;
    logic              ss_o;
    logic              sck_oe;
    logic              sdo_oe;
    logic              ss_oe;
    logic              irq;
  } port_t;

  port_t q;       // Current state
  port_t next_q;  // Next state

  logic             run;          // Engine allowed to advance
  logic             tick;         // Prescaled bit clock tick
  logic             tx_push, tx_pop, tx_full, tx_empty;
  logic             rx_push, rx_pop, rx_full, rx_empty;
  logic [7:0]       tx_head, rx_head;
  logic [CNT_W-1:0] tx_cnt, rx_cnt;
  logic             load_ev;      // Byte moved into shift register
  logic             done_ev;      // Byte fully shifted
  logic             drain_ev;     // Last unread byte read
  logic             do_write;     // Register write this cycle
  logic             do_read;      // Register read this cycle
  logic             samp_rise;    // Sampling on rising clock
  logic             s_rise, s_fall, s_samp, s_drive;
  logic [7:0]       sr_in;        // Shift register after a sample
  logic             sel_hit;      // Selected buffer condition

  // Halt when off, or when idle with stop-in-idle set
  assign run = q.en && !(q.sidl && IDLE_MODE_IN);

  // Framed operation always samples on rising clock
  assign samp_rise = q.framed_enable ? 1'b1 : !q.cke;

  // Slave clock edges from synchronised pin
  assign s_rise  = q.sck_sy[1] && !q.sck_sy[2];
  assign s_fall  = !q.sck_sy[1] && q.sck_sy[2];
  assign s_samp  = samp_rise ? s_rise : s_fall;
  assign s_drive = samp_rise ? s_fall : s_rise;

  spi_prescaler u_pre (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .run_in   (run && q.master && q.st != ENG_IDLE),
    .sel_in   (q.primary_prescale),
    .tick_out (tick)
  );

  spi_byte_fifo u_tx (
    .clk_in       (CLK_IN),
    .rst_n_in     (RST_N_IN),
    .flush_in     (!q.en),
    .deep_in      (q.ben),
    .push_in      (tx_push),
    .push_data_in (q.wdata[7:0]),
    .pop_in       (tx_pop),
    .head_out     (tx_head),
    .count_out    (tx_cnt),
    .full_out     (tx_full),
    .empty_out    (tx_empty)
  );

  spi_byte_fifo u_rx (
    .clk_in       (CLK_IN),
    .rst_n_in     (RST_N_IN),
    .flush_in     (!q.en),
    .deep_in      (q.ben),
    .push_in      (rx_push),
    // Master sampling on rising clock has the whole byte in the shift register already
    .push_data_in ((q.master && samp_rise) ? q.sr : sr_in),
    .pop_in       (rx_pop),
    .head_out     (rx_head),
    .count_out    (rx_cnt),
    .full_out     (rx_full),
    .empty_out    (rx_empty)
  );

  // Bus, registers, shift engine and events
  always_comb begin
    next_q   = q;
    tx_push  = 1'b0;
    tx_pop   = 1'b0;
    rx_push  = 1'b0;
    load_ev  = 1'b0;
    done_ev  = 1'b0;
    sr_in    = {q.sr[6:0], q.sdi_sy[1]};
    do_write = q.aw_held && q.w_held && !q.rsp.bvalid;
    do_read  = AXI_REQ_IN.arvalid && q.rsp.arready;
    rx_pop   = do_read && AXI_REQ_IN.araddr == OFF_BUFFER;
    drain_ev = rx_pop && rx_cnt == CNT_W'(1);

    // Pin synchronisers
    next_q.sck_sy = {q.sck_sy[1:0], SCK_IN};
    next_q.sdi_sy = {q.sdi_sy[0], SDI_IN};
    next_q.ss_sy  = {q.ss_sy[0], SS_IN};

    // Write address and data capture, either order
    if (AXI_REQ_IN.awvalid && q.rsp.awready) begin
      next_q.aw_held = 1'b1;
      next_q.awaddr  = AXI_REQ_IN.awaddr;
    end
    if (AXI_REQ_IN.wvalid && q.rsp.wready) begin
      next_q.w_held = 1'b1;
      next_q.wdata  = AXI_REQ_IN.wdata[15:0];
      next_q.wstrb  = AXI_REQ_IN.wstrb[1:0];
    end
    if (q.rsp.bvalid && AXI_REQ_IN.bready) begin
      next_q.rsp.bvalid = 1'b0;
    end

    // Register write, only implemented bits change
    if (do_write) begin
      next_q.aw_held    = 1'b0;
      next_q.w_held     = 1'b0;
      next_q.rsp.bvalid = 1'b1;
      next_q.rsp.bresp  = RESP_OKAY;
      if (q.awaddr == OFF_STATUS) begin
        if (q.wstrb[1]) begin
          next_q.en   = q.wdata[ST_EN];
          next_q.sidl = q.wdata[ST_SIDL];
        end
        if (q.wstrb[0]) begin
          next_q.buffer_irq_select = q.wdata[ST_BUFFER_IRQ_SELECT +: 3];
          if (!q.wdata[ST_ROV]) begin
            next_q.rov = 1'b0;
          end
        end
      end else if (q.awaddr == OFF_CON1) begin
        if (q.wstrb[1]) begin
          next_q.cke = q.wdata[C1_CKE];
        end
        if (q.wstrb[0]) begin
          next_q.master = q.wdata[C1_MASTER];
          next_q.primary_prescale   = q.wdata[C1_PRIMARY_PRESCALE +: 2];
        end
      end else if (q.awaddr == OFF_CON2) begin
        if (q.wstrb[1]) begin
          next_q.framed_enable = q.wdata[C2_FRAMED_ENABLE];
          next_q.fsd   = q.wdata[C2_FSD];
          next_q.fpol  = q.wdata[C2_FPOL];
        end
        if (q.wstrb[0]) begin
          next_q.fe  = q.wdata[C2_FE];
          next_q.ben = q.wdata[C2_BEN];
        end
      end else if (q.awaddr == OFF_BUFFER) begin
        tx_push = q.en && q.wstrb[0];
      end else begin
        next_q.rsp.bresp = RESP_SLVERR;
      end
    end

    // Register read, unimplemented bits zero
    if (q.rsp.rvalid && AXI_REQ_IN.rready) begin
      next_q.rsp.rvalid = 1'b0;
    end
    if (do_read) begin
      next_q.rsp.rvalid = 1'b1;
      next_q.rsp.rresp  = RESP_OKAY;
      next_q.rsp.rdata  = '0;
      if (AXI_REQ_IN.araddr == OFF_STATUS) begin
        next_q.rsp.rdata[ST_EN]       = q.en;
        next_q.rsp.rdata[ST_SIDL]     = q.sidl;
        next_q.rsp.rdata[ST_BEC +: 3] = q.master ? tx_cnt : rx_cnt;
        next_q.rsp.rdata[ST_SHIFT_REG_EMPTY]    = (q.st == ENG_IDLE);
        next_q.rsp.rdata[ST_ROV]      = q.rov;
        next_q.rsp.rdata[ST_RXMPT]    = rx_empty;
        next_q.rsp.rdata[ST_BUFFER_IRQ_SELECT +: 3] = q.buffer_irq_select;
        next_q.rsp.rdata[ST_TBF]      = tx_full;
        next_q.rsp.rdata[ST_RBF]      = rx_full;
      end else if (AXI_REQ_IN.araddr == OFF_CON1) begin
        next_q.rsp.rdata[C1_CKE]      = q.cke;
        next_q.rsp.rdata[C1_MASTER]   = q.master;
        next_q.rsp.rdata[C1_PRIMARY_PRESCALE +: 2] = q.primary_prescale;
      end else if (AXI_REQ_IN.araddr == OFF_CON2) begin
        next_q.rsp.rdata[C2_FRAMED_ENABLE]    = q.framed_enable;
        next_q.rsp.rdata[C2_FSD]      = q.fsd;
        next_q.rsp.rdata[C2_FPOL]     = q.fpol;
        next_q.rsp.rdata[C2_FE]       = q.fe;
        next_q.rsp.rdata[C2_BEN]      = q.ben;
      end else if (AXI_REQ_IN.araddr == OFF_BUFFER) begin
        next_q.rsp.rdata[7:0]         = rx_head;
      end else begin
        next_q.rsp.rresp              = RESP_SLVERR;
      end
    end

    // Shift engine
    if (!q.en) begin
      next_q.st     = ENG_IDLE;
      next_q.sck_o  = 1'b0;
      next_q.fs_act = 1'b0;
    end else if (run) begin
      case (q.st)
        ENG_IDLE: begin
          if (q.master && !tx_empty) begin
            // Master starts when a byte waits
            tx_pop       = 1'b1;
            load_ev      = 1'b1;
            next_q.sr    = tx_head;
            next_q.sdo_o = tx_head[7];
            next_q.hb    = '0;
            next_q.fs_act = q.framed_enable && !q.fsd;
            next_q.st    = (q.framed_enable && !q.fsd && !q.fe) ? ENG_PRE : ENG_SHIFT;
          end else if (!q.master && (q.framed_enable ? (q.ss_sy[1] == q.fpol) : !q.ss_sy[1])) begin
            // Slave starts on select or on frame pulse
            tx_pop       = !tx_empty;
            load_ev      = !tx_empty;
            next_q.sr    = tx_empty ? 8'h00 : tx_head;
            next_q.sdo_o = tx_empty ? 1'b0 : tx_head[7];
            next_q.hb    = (q.framed_enable && !q.fe) ? HB_LAST : 4'h0;
            next_q.st    = ENG_SHIFT;
          end
        end
        ENG_PRE: begin
          // Frame pulse one bit clock ahead of data
          if (tick) begin
            next_q.hb = q.hb + 4'h1;
            if (q.hb[0]) begin
              next_q.hb     = '0;
              next_q.fs_act = 1'b0;
              next_q.st     = ENG_SHIFT;
            end
          end
        end
        default: begin
          if (q.master) begin
            if (tick) begin
              next_q.hb    = q.hb + 4'h1;
              next_q.sck_o = !q.hb[0];
              if (q.hb == 4'h1) begin
                next_q.fs_act = 1'b0;
              end
              if (q.hb[0] == !samp_rise) begin
                next_q.sr = sr_in;
              end else if (q.hb != HB_LAST) begin
                next_q.sdo_o = q.sr[7];
              end
              if (q.hb == HB_LAST) begin
                done_ev   = 1'b1;
                next_q.st = ENG_IDLE;
              end
            end
          end else if (!q.framed_enable && q.ss_sy[1]) begin
            // Select dropped mid byte, abandon it
            next_q.st = ENG_IDLE;
          end else if (s_samp) begin
            next_q.hb = q.hb + 4'h1;
            if (q.hb != HB_LAST) begin
              next_q.sr = sr_in;
            end
            if (q.hb == 4'h7) begin
              done_ev   = 1'b1;
              next_q.st = ENG_IDLE;
            end
          end else if (s_drive) begin
            next_q.sdo_o = q.sr[7];
          end
        end
      endcase
    end

    // Finished byte to receive buffer, or overflow
    if (done_ev) begin
      if (rx_full) begin
        next_q.rov = 1'b1;
      end else begin
        rx_push = 1'b1;
      end
    end

    // Pin ownership follows enable, mode and frame direction
    next_q.sck_oe = q.en && q.master;
    next_q.sdo_oe = q.en && (q.master || q.framed_enable || !q.ss_sy[1]);
    next_q.ss_oe  = q.en && q.framed_enable && !q.fsd;
    next_q.ss_o   = next_q.fs_act ? q.fpol : !q.fpol;

    // Buffer event condition
    case (q.buffer_irq_select)
      IS_TX_FULL:  sel_hit = tx_full;
      IS_TX_EMPTY: sel_hit = done_ev && tx_empty;
      IS_TX_DONE:  sel_hit = done_ev;
      IS_TX_SPOT:  sel_hit = load_ev;
      IS_RX_FULL:  sel_hit = rx_full;
      IS_RX_3QTR:  sel_hit = q.ben ? rx_cnt >= RX_3QTR : rx_full;
      IS_RX_AVAIL: sel_hit = !rx_empty;
      default:     sel_hit = drain_ev;
    endcase
    next_q.irq = q.en && (q.ben ? sel_hit : done_ev);

    // Ready flags for the next beat
    next_q.rsp.awready = !next_q.aw_held;
    next_q.rsp.wready  = !next_q.w_held;
    next_q.rsp.arready = !next_q.rsp.rvalid;
  end

  // State register
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from state flops
  assign AXI_RSP_OUT      = q.rsp;
  assign SCK_OUT          = q.sck_o;
  assign SCK_OE_OUT       = q.sck_oe;
  assign SDO_OUT          = q.sdo_o;
  assign SDO_OE_OUT       = q.sdo_oe;
  assign SS_OUT           = q.ss_o;
  assign SS_OE_OUT        = q.ss_oe;
  assign BUFFER_EVENT_OUT = q.irq;
endmodule : spi_port_ctrl

// >>> inc/spi_port_pkg.sv
package spi_port_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CON1   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CON2   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_BUFFER = 8'h0c;

  // Status and control field positions
  localparam int ST_EN     = 15;
  localparam int ST_SIDL   = 13;
  localparam int ST_BEC    = 8;
  localparam int ST_SHIFT_REG_EMPTY  = 7;
  localparam int ST_ROV    = 6;
  localparam int ST_RXMPT  = 5;
  localparam int ST_BUFFER_IRQ_SELECT  = 2;
  localparam int ST_TBF    = 1;
  localparam int ST_RBF    = 0;

  // Control one field positions
  localparam int C1_CKE    = 8;
  localparam int C1_MASTER = 5;
  localparam int C1_PRIMARY_PRESCALE   = 0;

  // Control two field positions
  localparam int C2_FRAMED_ENABLE  = 15;
  localparam int C2_FSD    = 14;
  localparam int C2_FPOL   = 13;
  localparam int C2_FE     = 1;
  localparam int C2_BEN    = 0;

  // Reset value of every register except status, where ST_SHIFT_REG_EMPTY and ST_RXMPT read as one
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Buffer geometry
  localparam int          FIFO_DEPTH = 4;
  localparam int          CNT_W      = 3;
  localparam int          BYTE_W     = 8;
  localparam logic [2:0]  RX_3QTR    = 3'h3;

  // Prescale divide counts
  localparam logic [6:0]  PRE_DIV_1  = 7'h01;
  localparam logic [6:0]  PRE_DIV_4  = 7'h04;
  localparam logic [6:0]  PRE_DIV_16 = 7'h10;
  localparam logic [6:0]  PRE_DIV_64 = 7'h40;

  // Half bit clock slots per byte, last index
  localparam logic [3:0]  HB_LAST    = 4'hf;

  // Buffer event select codes
  localparam logic [2:0]  IS_TX_FULL  = 3'h7;
  localparam logic [2:0]  IS_TX_EMPTY = 3'h6;
  localparam logic [2:0]  IS_TX_DONE  = 3'h5;
  localparam logic [2:0]  IS_TX_SPOT  = 3'h4;
  localparam logic [2:0]  IS_RX_FULL  = 3'h3;
  localparam logic [2:0]  IS_RX_3QTR  = 3'h2;
  localparam logic [2:0]  IS_RX_AVAIL = 3'h1;
  localparam logic [2:0]  IS_RX_DRAIN = 3'h0;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Bus request from the master
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axi_req_t;

  // Bus answer to the master
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } axi_rsp_t;

endpackage : spi_port_pkg

// >>> src/spi_prescaler.sv
`timescale 1ns/1ps
module spi_prescaler (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       run_in,
  input  wire logic [1:0] sel_in,
  output logic            tick_out
);
  import spi_port_pkg::*;

  // Whole state
  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } pre_t;

  pre_t q;       // Current state
  pre_t next_q;  // Next state
  logic [6:0] div;  // Selected divide count

  // Divider selection and count
  always_comb begin
    next_q = q;
    case (sel_in)
      2'h3:    div = PRE_DIV_1;
      2'h2:    div = PRE_DIV_4;
      2'h1:    div = PRE_DIV_16;
      default: div = PRE_DIV_64;
    endcase
    next_q.tick = 1'b0;
    if (!run_in) begin
      next_q.cnt = 7'h00;
    end else if (q.cnt + 7'h01 >= div) begin
      next_q.cnt  = 7'h00;
      next_q.tick = 1'b1;
    end else begin
      next_q.cnt = q.cnt + 7'h01;
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tick_out = q.tick;
endmodule : spi_prescaler

// >>> src/spi_byte_fifo.sv
`timescale 1ns/1ps
module spi_byte_fifo (
  input  wire logic                           clk_in,
  input  wire logic                           rst_n_in,
  input  wire logic                           flush_in,
  input  wire logic                           deep_in,
  input  wire logic                           push_in,
  input  wire logic [spi_port_pkg::BYTE_W-1:0] push_data_in,
  input  wire logic                           pop_in,
  output logic      [spi_port_pkg::BYTE_W-1:0] head_out,
  output logic      [spi_port_pkg::CNT_W-1:0]  count_out,
  output logic                                full_out,
  output logic                                empty_out
);
  import spi_port_pkg::*;

  // Whole state
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][BYTE_W-1:0] mem;
    logic [1:0]                        rd;
    logic [1:0]                        wr;
    logic [CNT_W-1:0]                  cnt;
  } fifo_t;

  fifo_t q;       // Current state
  fifo_t next_q;  // Next state
  logic  do_push; // Accepted write
  logic  do_pop;  // Accepted read

  // Deep mode holds four bytes, legacy mode one
  assign full_out  = deep_in ? (q.cnt == CNT_W'(FIFO_DEPTH)) : (q.cnt != '0);
  assign empty_out = (q.cnt == '0);
  assign head_out  = q.mem[q.rd];
  assign count_out = q.cnt;

  // Pointer and count update
  always_comb begin
    next_q  = q;
    do_push = push_in && !full_out;
    do_pop  = pop_in && !empty_out;
    if (flush_in) begin
      next_q.rd  = '0;
      next_q.wr  = '0;
      next_q.cnt = '0;
    end else begin
      if (do_push) begin
        next_q.mem[q.wr] = push_data_in;
        next_q.wr        = q.wr + 2'h1;
      end
      if (do_pop) begin
        next_q.rd = q.rd + 2'h1;
      end
      next_q.cnt = q.cnt + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule : spi_byte_fifo

// >>> tb/spi_port_ctrl_chk.sv
`timescale 1ns/1ps
module spi_port_ctrl_chk (
  input  wire logic                   CLK_IN,
  input  wire logic                   RST_N_IN,
  input  wire spi_port_pkg::axi_req_t AXI_REQ_IN,
  input  wire spi_port_pkg::axi_rsp_t AXI_RSP_OUT
);
  import spi_port_pkg::*;
  wire axi_req_t q = AXI_REQ_IN;  // Short alias of the request
  wire axi_rsp_t s = AXI_RSP_OUT; // Short alias of the answer
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Write answer comes two cycles after both halves are taken in one cycle
  a_write_answer: assert property (
    q.awvalid && s.awready && q.wvalid && s.wready |=> ##1 s.bvalid)
    else $error("write answer late");
  // Write address held off the cycle after it is taken
  a_aw_wait: assert property (q.awvalid && s.awready |=> !s.awready)
    else $error("write address taken twice");
  a_read_answer: assert property (q.arvalid && s.arready |=> s.rvalid)
    else $error("read answer late");
  a_ar_block: assert property (s.rvalid |-> !s.arready)
    else $error("read taken during answer");
  // Answers drop once accepted
  a_b_release: assert property (s.bvalid && q.bready |=> !s.bvalid)
    else $error("write answer stuck");
  a_r_release: assert property (s.rvalid && q.rready |=> !s.rvalid)
    else $error("read answer stuck");
  a_err_zero: assert property (
    s.rvalid && s.rresp == RESP_SLVERR |-> s.rdata == 32'h0)
    else $error("error read not zero");
  a_upper_zero: assert property (s.rvalid |-> s.rdata[31:16] == 16'h0)
    else $error("upper half not zero");
endmodule : spi_port_ctrl_chk
bind spi_port_ctrl spi_port_ctrl_chk spi_port_ctrl_chk_inst (.CLK_IN(CLK_IN),
  .RST_N_IN(RST_N_IN), .AXI_REQ_IN(AXI_REQ_IN), .AXI_RSP_OUT(AXI_RSP_OUT));

// >>> tb/spi_partner.sv
`timescale 1ns/1ps
module spi_partner #(
  parameter logic [7:0] REPLY = 8'h96
) (
  input  wire logic       sck_in,
  input  wire logic       sdo_in,
  output logic            sdi_out,
  output logic      [7:0] got_out,
  output int              count_out
);
  logic [7:0] shift; // Incoming bits
  logic [2:0] bit_n; // Bit index in byte
  initial begin
    sdi_out = REPLY[7];
    bit_n = 3'h0;
    count_out = 0;
    got_out = 8'h0;
    shift = 8'h0;
  end
  // Sample on rising clock, MSB first
  always @(posedge sck_in) begin
    shift <= {shift[6:0], sdo_in};
    bit_n <= bit_n + 3'h1;
    if (bit_n == 3'h7) begin
      got_out <= {shift[6:0], sdo_in};
      count_out <= count_out + 1;
    end
  end
  // Present next reply bit on falling clock
  always @(negedge sck_in) sdi_out <= REPLY[3'h7 - bit_n];
endmodule : spi_partner

// >>> tb/spi_port_ctrl_tb.sv
`timescale 1ns/1ps
module spi_port_ctrl_tb;
  import spi_port_pkg::*;
  logic       clk, rst_n, idle, sck_o, sck_oe, sdo_o, sdo_oe, ss_o, ss_oe, evt_o, sdi;
  logic       sck_w, sdo_w, ss_w;
  axi_req_t   req;
  axi_rsp_t   rsp;
  logic [1:0] resp;   // Last bus response
  logic [7:0] got;    // Last byte seen by partner
  int         cnt, fail_count, compares, t, k;
  assign sck_w = sck_oe ? sck_o : 1'b0; // Pull-down on idle clock
  assign sdo_w = sdo_oe ? sdo_o : 1'b1;
  assign ss_w  = ss_oe ? ss_o : 1'b1;
  always #12.5 clk = ~clk;
  spi_port_ctrl spi_port_ctrl_inst (.CLK_IN(clk), .RST_N_IN(rst_n), .IDLE_MODE_IN(idle),
    .AXI_REQ_IN(req), .AXI_RSP_OUT(rsp), .SCK_IN(sck_w), .SCK_OUT(sck_o), .SCK_OE_OUT(sck_oe),
    .SDO_OUT(sdo_o), .SDO_OE_OUT(sdo_oe), .SDI_IN(sdi), .SS_IN(ss_w), .SS_OUT(ss_o),
    .SS_OE_OUT(ss_oe), .BUFFER_EVENT_OUT(evt_o));
  spi_partner spi_partner_inst (.sck_in(sck_w), .sdo_in(sdo_w), .sdi_out(sdi), .got_out(got),
    .count_out(cnt));
  task automatic complete_run();
    $display("Compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bound(input int i, input int lim);
    if (i >= lim) begin
      fail_count++;
      $display("BAD %0t wait ran out", $time);
      complete_run();
    end
  endtask : bound
  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int i;
    @(posedge clk);
    req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: {16'h0, d}, wstrb: 4'hf,
             bready: 1'b1, default: '0};
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    bound(i, 200);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int i;
    @(posedge clk);
    req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    bound(i, 200);
    d = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rc
  // Poll until shift register empty and nothing pending
  task automatic wait_idle();
    logic [31:0] d;
    int          i;
    for (i = 0; i < 500; i++) begin
      rd(OFF_STATUS, d);
      if (d[ST_SHIFT_REG_EMPTY] === 1'b1 && d[10:8] === 3'h0) break;
    end
    bound(i, 500);
  endtask : wait_idle
  task automatic ev(input logic e);
    repeat (3) @(posedge clk);
    chk({31'h0, evt_o}, {31'h0, e});
  endtask : ev
  // Cycles up to the next rising serial clock
  task automatic rise(output int n);
    logic p;
    int   i;
    p = sck_w;
    for (i = 0; i < 500; i++) begin
      @(posedge clk);
      if (sck_w && !p) break;
      p = sck_w;
    end
    bound(i, 500);
    n = i + 1;
  endtask : rise
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    idle = 1'b0;
    req = '0;
    fail_count = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rc(OFF_CON1, 32'h0);
    rc(OFF_CON2, 32'h0);
    wr(OFF_CON1, 16'hffff);
    rc(OFF_CON1, 32'h0123);
    wr(OFF_CON1, 16'h0022);
    wr(OFF_CON2, 16'hffff);
    rc(OFF_CON2, 32'he003);
    wr(OFF_CON2, 16'h0001);
    wr(8'h10, 16'h1234);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    rc(8'h10, 32'h0);
    wr(OFF_STATUS, 16'hffff);
    rc(OFF_STATUS, 32'ha0bc);
    for (k = 0; k < 3; k++) wr(OFF_BUFFER, 16'h00a5 + k[15:0]);
    wait_idle();
    chk({24'h0, got}, 32'ha7);
    rc(OFF_STATUS, 32'ha09c);
    repeat (3) rc(OFF_BUFFER, 32'h96);
    // Five bytes into a four deep receive buffer
    wr(OFF_STATUS, 16'ha00c);
    for (k = 0; k < 5; k++) wr(OFF_BUFFER, 16'h0011 + k[15:0]);
    wait_idle();
    rc(OFF_STATUS, 32'ha0cd);
    ev(1'b1);
    wr(OFF_STATUS, 16'ha004);
    ev(1'b1);
    rc(OFF_STATUS, 32'ha085);
    repeat (3) rc(OFF_BUFFER, 32'h96);
    // Last read empties the buffer, drain pulse stands during the answer
    wr(OFF_STATUS, 16'ha000);
    rc(OFF_BUFFER, 32'h96);
    chk({31'h0, evt_o}, 32'h1);
    wr(OFF_STATUS, 16'ha008);
    ev(1'b0);
    rc(OFF_STATUS, 32'ha0a8);
    wr(OFF_STATUS, 16'h0000);
    @(posedge clk); // Pin enables settle a cycle after the write
    chk({31'h0, sck_oe}, 32'h0);
    wr(OFF_CON2, 16'h8001);
    wr(OFF_STATUS, 16'ha00c);
    @(posedge clk);
    chk({31'h0, ss_oe}, 32'h1);
    chk({31'h0, sck_oe}, 32'h1);
    chk({31'h0, ss_o}, 32'h1);
    wr(OFF_CON2, 16'hc001);
    @(posedge clk);
    chk({31'h0, ss_oe}, 32'h0);
    wr(OFF_CON2, 16'h0001);
    // Engine frozen while the device idles
    idle <= 1'b1;
    wr(OFF_BUFFER, 16'h005a);
    repeat (100) @(posedge clk);
    chk(cnt, 8);
    idle <= 1'b0;
    wait_idle();
    chk({24'h0, got}, 32'h5a);
    for (k = 0; k < 4; k++) begin
      wr(OFF_CON1, 16'h0020 | k[15:0]);
      wr(OFF_BUFFER, 16'h0000);
      rise(t);
      rise(t);
      chk(t, 2 << (2 * (3 - k)));
      wait_idle();
    end
    complete_run();
  end
endmodule : spi_port_ctrl_tb
